// >>> design/mbf_pkg.sv
// Shared constants, types and register map of the marker block fill engine
package mbf_pkg;

	// Register map, byte addresses on the APB
	localparam int             APB_AW       = 8;
	localparam logic [7:0]     REG_CTRL     = 8'h00;
	localparam logic [7:0]     REG_SRC      = 8'h04;
	localparam logic [7:0]     REG_DST      = 8'h08;
	localparam logic [7:0]     REG_COUNT    = 8'h0C;
	localparam logic [7:0]     REG_STATUS   = 8'h10;
	localparam logic [7:0]     REG_MEM_ADDR = 8'h14;
	localparam logic [7:0]     REG_MEM_DATA = 8'h18;

	// Field positions
	localparam int             CTRL_TRIG_BIT = 0;
	localparam int             CTRL_MODE_BIT = 1;
	localparam int             OPV_LSB       = 0;
	localparam int             OPV_MSB       = 15;
	localparam int             OPK_LSB       = 16;
	localparam int             OPK_MSB       = 17;
	localparam int             ST_FLAG_MSB   = 2;
	localparam int             ST_BUSY_BIT   = 3;
	localparam int             ST_REJ_BIT    = 4;
	localparam int             ST_MODE_BIT   = 5;

	// Operand width and legal byte counts
	localparam int             OPER_W        = 16;
	localparam int             MIN_CNT       = 1;
	localparam int             FILL_MAX_CNT  = 192;
	localparam int             COPY_MAX_CNT  = 383;
	localparam int             WORD_SHIFT    = 1;
	localparam int             DWORD_SHIFT   = 2;

	// Execution time anchor points
	localparam int             CLK_PERIOD_NS = 20;
	localparam int             PT_1B         = 1;
	localparam int             PT_10B        = 10;
	localparam int             PT_100B       = 100;
	localparam int             T_1B_US       = 54;
	localparam int             T_10B_US      = 60;
	localparam int             T_100B_US     = 71;
	localparam int             NS_PER_US     = 1000;
	localparam int             CYC_1B        = T_1B_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int             CYC_10B       = T_10B_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int             CYC_100B      = T_100B_US * NS_PER_US / CLK_PERIOD_NS;

	typedef enum logic [1:0] {MBF_OP_NUM, MBF_OP_BYTE, MBF_OP_WORD, MBF_OP_DWORD} mbf_optype_t;
	typedef enum logic {MBF_FILL, MBF_COPY} mbf_mode_t;

	typedef struct packed {
		mbf_optype_t            kind;
		logic [OPER_W-1:0]      value;
	} mbf_operand_t;

	typedef struct packed {
		logic                   invalid_offset;
		logic                   overlap;
		logic                   range_exceeded;
	} mbf_flags_t;

endpackage : mbf_pkg

// >>> design/mbf_fifo.sv
// Byte FIFO between the source reader and the destination writer
`timescale 1ns/10ps
module mbf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || WIDTH < 1) begin : g_chk
		$error("fifo depth must be at least 2 and width at least 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wp_q;
	logic [PW-1:0]    rp_q;
	logic [PW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest full and empty from the fill count
	assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers and fill count, wrapping at the depth
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (pop) rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule : mbf_fifo

// >>> design/mbf_engine.sv
// Marker block fill engine with marker memory and APB register slave
//
// Functional notes
// - Fill mode reads exactly one source byte as the pattern.
// - Pattern byte written to each destination byte for the requested count.
// - Only a 0 to 1 change of the trigger starts one transfer.
// - Error flags evaluated every cycle from current operands, trigger or not.
// - With any error flag set a trigger writes nothing to memory.
// - Run time grows with count: about 54, 60, 71 us for 1, 10, 100.
// - Range flag when start plus count passes the end of its area.
// - Invalid offset flag when count is outside 1 to 192 in fill mode.
// - A numeric operand is a byte offset from the first marker byte.
// - Everything counts in bytes; doublewords are four bytes, low byte first.
// - Mode selects fill or copy; fill after reset.
// - Overlap flag when source and destination ranges share any byte.
// - Word or doubleword index maps to offset (index-1) times 2 or 4.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module mbf_engine
	import mbf_pkg::*;
#(
	parameter int MEM_BYTES   = 512,
	parameter int BYTE_AREA   = 512,
	parameter int WORD_AREA   = 512,
	parameter int DWORD_AREA  = 512,
	parameter int FIFO_DEPTH  = 32
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// APB slave
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Status
	output logic                   range_exceeded_flag,
	output logic                   range_overlap_flag,
	output logic                   invalid_offset_flag,
	output logic                   busy
);
	localparam int AW = $clog2(MEM_BYTES);
	localparam int XW = 20;

	if (MEM_BYTES < 4 || MEM_BYTES > 65536 || BYTE_AREA > MEM_BYTES || WORD_AREA > MEM_BYTES
		|| DWORD_AREA > MEM_BYTES || FIFO_DEPTH < 2) begin : g_chk
		$error("marker memory, area or fifo parameters out of range");
	end

	typedef enum {ST_IDLE, ST_RUN} mbf_state_t;

	// Marker memory, one byte per entry
	logic [7:0]         mem_q [MEM_BYTES];

	// Register state
	logic               trig_q;
	logic               trig_prev_q;
	mbf_mode_t          mode_q;
	mbf_operand_t       src_op_q;
	mbf_operand_t       dst_op_q;
	logic [OPER_W-1:0]  count_q;
	logic [AW-1:0]      mem_addr_q;
	logic               rej_q;
	mbf_flags_t         flags_q;

	// Engine state
	mbf_state_t         state_q;
	mbf_mode_t          run_mode_q;
	logic [AW-1:0]      run_src_q;
	logic [AW-1:0]      run_dst_q;
	logic [OPER_W-1:0]  run_cnt_q;
	logic [OPER_W-1:0]  rd_cnt_q;
	logic [OPER_W-1:0]  wr_cnt_q;
	logic [7:0]         pattern_q;
	logic [15:0]        timer_q;
	logic [15:0]        target_q;

	// APB answer registers
	logic [31:0]        prdata_q;
	logic               pready_q;
	logic               pslverr_q;

	// Byte offset of an operand from the first marker byte
	function automatic logic [XW-1:0] byte_off(mbf_operand_t op);
		logic [XW-1:0] v;
		v = XW'(op.value);
		case (op.kind)
			MBF_OP_BYTE:  byte_off = v - 1'b1;
			MBF_OP_WORD:  byte_off = (v - 1'b1) << WORD_SHIFT;
			MBF_OP_DWORD: byte_off = (v - 1'b1) << DWORD_SHIFT;
			default:      byte_off = v;
		endcase
	endfunction : byte_off

	// End of the addressable area for an operand type
	function automatic logic [XW-1:0] area_end(mbf_optype_t kind);
		case (kind)
			MBF_OP_BYTE:  area_end = XW'(BYTE_AREA);
			MBF_OP_WORD:  area_end = XW'(WORD_AREA);
			MBF_OP_DWORD: area_end = XW'(DWORD_AREA);
			default:      area_end = XW'(MEM_BYTES);
		endcase
	endfunction : area_end

	// Run time in cycles, piecewise between the three anchor points
	function automatic logic [15:0] target_cycles(logic [OPER_W-1:0] n);
		int k;
		k = int'(n);
		if (k <= PT_10B) begin
			target_cycles = 16'(CYC_1B + (k - PT_1B) * (CYC_10B - CYC_1B) / (PT_10B - PT_1B));
		end else begin
			target_cycles = 16'(CYC_10B + (k - PT_10B) * (CYC_100B - CYC_10B)
				/ (PT_100B - PT_10B));
		end
	endfunction : target_cycles

	// Range checks on the current operands, independent of the trigger
	wire [XW-1:0] src_off  = byte_off(src_op_q);
	wire [XW-1:0] dst_off  = byte_off(dst_op_q);
	wire [XW-1:0] src_len  = (mode_q == MBF_FILL) ? XW'(1) : XW'(count_q);
	wire [XW-1:0] dst_len  = XW'(count_q);
	wire [XW-1:0] src_end  = src_off + src_len;
	wire [XW-1:0] dst_end  = dst_off + dst_len;
	wire [XW-1:0] cnt_max  = (mode_q == MBF_FILL) ? XW'(FILL_MAX_CNT) : XW'(COPY_MAX_CNT);
	wire          e_range  = (dst_end > area_end(dst_op_q.kind))
		|| (src_end > area_end(src_op_q.kind))
		|| (dst_off >= XW'(MEM_BYTES)) || (src_off >= XW'(MEM_BYTES));
	wire          e_ovl    = (src_off < dst_end) && (dst_off < src_end);
	wire          e_cnt    = (dst_len < XW'(MIN_CNT)) || (dst_len > cnt_max);
	mbf_flags_t   flags_d;
	assign flags_d = '{invalid_offset: e_cnt, overlap: e_ovl, range_exceeded: e_range};
	wire          any_err  = e_range | e_ovl | e_cnt;

	// Start decision on a trigger rising edge
	wire          trig_edge = trig_q & ~trig_prev_q;
	wire          start     = trig_edge && (state_q == ST_IDLE) && !any_err;
	wire          reject    = trig_edge && (state_q == ST_IDLE) && any_err;

	// APB decode
	wire          apb_setup = psel & ~penable;
	wire          apb_wr    = psel & penable & pwrite & pready_q;
	wire          sel_ctrl  = (paddr == REG_CTRL);
	wire          sel_src   = (paddr == REG_SRC);
	wire          sel_dst   = (paddr == REG_DST);
	wire          sel_cnt   = (paddr == REG_COUNT);
	wire          sel_stat  = (paddr == REG_STATUS);
	wire          sel_maddr = (paddr == REG_MEM_ADDR);
	wire          sel_mdata = (paddr == REG_MEM_DATA);
	wire          mapped    = sel_ctrl | sel_src | sel_dst | sel_cnt | sel_stat
		| sel_maddr | sel_mdata;
	wire          bus_mem_wr = apb_wr & sel_mdata;

	// Read data multiplexer
	logic [31:0]  rd_mux;
	always_comb begin
		rd_mux = '0;
		if (sel_ctrl) begin
			rd_mux[CTRL_TRIG_BIT] = trig_q;
			rd_mux[CTRL_MODE_BIT] = mode_q;
		end
		if (sel_src) rd_mux[OPK_MSB:OPV_LSB] = src_op_q;
		if (sel_dst) rd_mux[OPK_MSB:OPV_LSB] = dst_op_q;
		if (sel_cnt) rd_mux[OPV_MSB:OPV_LSB] = count_q;
		if (sel_stat) begin
			rd_mux[ST_FLAG_MSB:0] = flags_q;
			rd_mux[ST_BUSY_BIT]   = (state_q == ST_RUN);
			rd_mux[ST_REJ_BIT]    = rej_q;
			rd_mux[ST_MODE_BIT]   = mode_q;
		end
		if (sel_maddr) rd_mux[AW-1:0] = mem_addr_q;
		if (sel_mdata) rd_mux[7:0] = mem_q[mem_addr_q];
	end

	// APB answer: ready in the access phase after every setup cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup & ~mapped;
			prdata_q  <= (apb_setup & ~pwrite) ? rd_mux : '0;
		end
	end

	// Software registers; mode defaults to fill
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_q     <= 1'b0;
			mode_q     <= MBF_FILL;
			src_op_q   <= '0;
			dst_op_q   <= '0;
			count_q    <= '0;
			mem_addr_q <= '0;
		end else if (apb_wr) begin
			if (sel_ctrl) trig_q <= pwdata[CTRL_TRIG_BIT];
			if (sel_ctrl) mode_q <= mbf_mode_t'(pwdata[CTRL_MODE_BIT]);
			if (sel_src) src_op_q <= pwdata[OPK_MSB:OPV_LSB];
			if (sel_dst) dst_op_q <= pwdata[OPK_MSB:OPV_LSB];
			if (sel_cnt) count_q <= pwdata[OPV_MSB:OPV_LSB];
			if (sel_maddr) mem_addr_q <= pwdata[AW-1:0];
		end
	end

	// Trigger history, error flags sampled every cycle, reject marker
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_prev_q <= 1'b0;
			flags_q     <= '0;
			rej_q       <= 1'b0;
		end else begin
			trig_prev_q <= trig_q;
			flags_q     <= flags_d;
			if (reject) rej_q <= 1'b1;
			else if (start) rej_q <= 1'b0;
		end
	end

	// Reader: one pattern byte in fill mode, ascending source bytes in copy mode
	wire          rd_valid  = (state_q == ST_RUN) && (rd_cnt_q < run_cnt_q);
	wire [AW-1:0] rd_addr   = run_src_q + AW'(rd_cnt_q);
	wire [7:0]    rd_data   = (run_mode_q == MBF_FILL) ? pattern_q : mem_q[rd_addr];
	logic         rd_ready;
	logic         wr_valid;
	logic [7:0]   wr_data;
	wire          wr_ready  = (state_q == ST_RUN) & ~bus_mem_wr;
	wire          wr_fire   = wr_valid & wr_ready;
	wire [AW-1:0] wr_addr   = run_dst_q + AW'(wr_cnt_q);
	wire          data_done = (wr_cnt_q == run_cnt_q);
	wire          time_done = (timer_q >= target_q);

	mbf_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (rd_valid),
		.in_ready  (rd_ready),
		.in_data   (rd_data),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  (wr_data)
	);

	// Engine sequencing and operand capture
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			run_mode_q <= MBF_FILL;
			run_src_q  <= '0;
			run_dst_q  <= '0;
			run_cnt_q  <= '0;
			pattern_q  <= '0;
			target_q   <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q    <= ST_RUN;
						run_mode_q <= mode_q;
						run_src_q  <= src_off[AW-1:0];
						run_dst_q  <= dst_off[AW-1:0];
						run_cnt_q  <= count_q;
						pattern_q  <= mem_q[src_off[AW-1:0]];
						target_q   <= target_cycles(count_q) - 16'd1;
					end
				end
				ST_RUN: begin
					if (data_done && time_done) state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Byte counters and the run-time counter
	always_ff @(posedge clk) begin
		if (rst || start) begin
			rd_cnt_q <= '0;
			wr_cnt_q <= '0;
			timer_q  <= '0;
		end else if (state_q == ST_RUN) begin
			if (rd_valid && rd_ready) rd_cnt_q <= rd_cnt_q + 1'b1;
			if (wr_fire) wr_cnt_q <= wr_cnt_q + 1'b1;
			if (!time_done) timer_q <= timer_q + 16'd1;
		end
	end

	// Memory write port: software window has priority, the writer stalls
	always_ff @(posedge clk) begin
		if (bus_mem_wr) begin
			mem_q[mem_addr_q] <= pwdata[7:0];
		end else if (wr_fire) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Registered status outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			range_exceeded_flag <= 1'b0;
			range_overlap_flag  <= 1'b0;
			invalid_offset_flag <= 1'b0;
			busy                <= 1'b0;
		end else begin
			range_exceeded_flag <= flags_d.range_exceeded;
			range_overlap_flag  <= flags_d.overlap;
			invalid_offset_flag <= flags_d.invalid_offset;
			busy                <= start | ((state_q == ST_RUN) & ~(data_done & time_done));
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule : mbf_engine

// >>> tb/mbf_engine_assertions.sv
// Port checks of the fill engine
`timescale 1ns/10ps
module mbf_engine_chk
	import mbf_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// APB
	input wire logic [APB_AW-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Status
	input wire logic              range_exceeded_flag,
	input wire logic              range_overlap_flag,
	input wire logic              invalid_offset_flag,
	input wire logic              busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Accepted writes, trigger and operand writes, error summary
	wire wr_acc = psel && penable && pwrite && pready;
	wire wr_trig = wr_acc && paddr == REG_CTRL && pwdata[CTRL_TRIG_BIT];
	wire wr_op = wr_acc && paddr inside {REG_CTRL, REG_SRC, REG_DST, REG_COUNT};
	wire any_err = range_exceeded_flag || range_overlap_flag || invalid_offset_flag;
	wire [2:0] flags = {invalid_offset_flag, range_overlap_flag, range_exceeded_flag};
	logic [15:0] busy_n_q;
	// Length of the running operation
	always_ff @(posedge clk) begin
		if (rst || !busy) busy_n_q <= 16'h0000;
		else busy_n_q <= busy_n_q + 16'h0001;
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_start_on_edge: assert property ($rose(busy) |-> $past(wr_trig, 2))
		else $error("start without trigger edge");
	a_start_clean: assert property ($rose(busy) |-> !$past(any_err))
		else $error("start with error flag");
	a_busy_min_time: assert property ($fell(busy) |-> busy_n_q >= 16'(CYC_1B - 8))
		else $error("operation too short");
	a_busy_holds: assert property ($rose(busy) |-> busy [*8])
		else $error("busy pulse too short");
	a_flag_cause: assert property ($changed(flags) |-> $past(wr_op) || $past(wr_op, 2) || $past(rst, 2))
		else $error("flags moved without operand change");
	c_done: cover property ($fell(busy));
	c_refused: cover property (wr_trig && any_err);
	c_unmapped: cover property (pslverr);
endmodule : mbf_engine_chk

bind mbf_engine mbf_engine_chk u_chk (
	.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .range_exceeded_flag(range_exceeded_flag),
	.range_overlap_flag(range_overlap_flag), .invalid_offset_flag(invalid_offset_flag),
	.busy(busy)
);

// >>> tb/mbf_host.sv
// APB master standing in for the user logic program
`timescale 1ns/10ps
module mbf_host
	import mbf_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Request
	output logic [APB_AW-1:0]      paddr,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic [31:0]            pwdata,
	// Answer
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0000_0000;
	end
	// One transfer, held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e, output logic to);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		// Answer and read data are taken at the rising edge that shows pready
		@(posedge clk);
		while (pready !== 1'b1 && i < 64) begin
			@(posedge clk);
			i++;
		end
		q = prdata;
		e = pslverr;
		to = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : mbf_host

// >>> tb/mbf_engine_tb.sv
// Self-checking bench of the marker block fill engine
`timescale 1ns/10ps
module mbf_engine_tb
	import mbf_pkg::*;
;
	// Clock, reset, bus and status
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [APB_AW-1:0] paddr;
	logic              psel, penable, pwrite, pready, pslverr, busy, last_err;
	logic [31:0]       pwdata, prdata;
	logic              f_rng, f_ovl, f_inv;
	int                n_fail = 0;
	int                n_checks = 0;
	always #10 clk = ~clk;
	mbf_engine uut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .range_exceeded_flag(f_rng), .range_overlap_flag(f_ovl),
		.invalid_offset_flag(f_inv), .busy(busy));
	mbf_host u_host (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	// Bus access; a lost answer ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic to;
		u_host.xfer(w, a, d, q, last_err, to);
		if (to) begin
			check("bus answer", 1'b0, 1'b1);
			results();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic mset(input int a, input logic [7:0] v);
		wr(REG_MEM_ADDR, 32'(a));
		wr(REG_MEM_DATA, 32'(v));
	endtask : mset
	task automatic mchk(input int a, input logic [7:0] v, input string what);
		logic [31:0] q;
		wr(REG_MEM_ADDR, 32'(a));
		bus(1'b0, REG_MEM_DATA, 32'h0000_0000, q);
		check(what, q, 32'(v));
	endtask : mchk
	function automatic logic [31:0] op(input mbf_optype_t k, input int v);
		return {14'h0000, k, 16'(v)};
	endfunction : op
	function automatic int tgt(input int n);
		if (n <= PT_10B) return CYC_1B + (n - 1) * (CYC_10B - CYC_1B) / 9;
		else return CYC_10B + (n - PT_10B) * (CYC_100B - CYC_10B) / 90;
	endfunction : tgt
	// Operands change only while idle
	task automatic setops(input int s, input logic [31:0] t, input int n);
		wr(REG_SRC, op(MBF_OP_BYTE, s));
		wr(REG_DST, t);
		wr(REG_COUNT, 32'(n));
	endtask : setops
	// Busy length after a start, zero if none
	task automatic watch(output int cyc);
		cyc = 0;
		for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
		while (busy === 1'b1 && cyc < 20000) begin
			@(negedge clk);
			cyc++;
		end
		if (cyc >= 20000) begin
			check("busy timeout", 1'b0, 1'b1);
			results();
		end
	endtask : watch
	task automatic go(output int cyc);
		wr(REG_CTRL, 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0001);
		watch(cyc);
	endtask : go
	task automatic t_reset();
		logic [31:0] q;
		bus(1'b0, REG_STATUS, 32'h0000_0000, q);
		check("status after reset", q, 32'h0000_0004);
		wr(REG_CTRL, 32'h0000_0002);
		bus(1'b0, REG_STATUS, 32'h0000_0000, q);
		check("copy mode", q[ST_MODE_BIT], 1'b1);
		wr(REG_CTRL, 32'h0000_0000);
		bus(1'b0, 8'h1C, 32'h0000_0000, q);
		check("unmapped error", last_err, 1'b1);
		$display("Test reset done");
	endtask : t_reset
	task automatic t_fill();
		int sk[6] = '{10, 15, 60, 10, 1, 2};
		mbf_optype_t dk[6] = '{MBF_OP_BYTE, MBF_OP_NUM, MBF_OP_DWORD, MBF_OP_WORD,
			MBF_OP_NUM, MBF_OP_NUM};
		int dv[6] = '{20, 64, 80, 3, 100, 300};
		int da[6] = '{19, 64, 316, 4, 100, 300};
		int n[6] = '{10, 4, 8, 1, 100, 192};
		logic [7:0] p;
		int cyc;
		for (int i = 0; i < 6; i++) begin
			p = 8'h2D + 8'(i);
			mset(sk[i] - 1, p);
			mset(sk[i], ~p);
			mset(da[i] - 1, 8'h5A);
			mset(da[i] + n[i], 8'h5A);
			setops(sk[i], op(dk[i], dv[i]), n[i]);
			go(cyc);
			check("run time", cyc > tgt(n[i]) - 10 && cyc < tgt(n[i]) + 10, 1'b1);
			for (int j = 0; j < n[i]; j++) mchk(da[i] + j, p, "filled");
			mchk(da[i] - 1, 8'h5A, "below");
			mchk(da[i] + n[i], 8'h5A, "above");
			mchk(sk[i], ~p, "next source");
		end
		$display("Test fill done");
	endtask : t_fill
	task automatic t_err();
		int sk[4] = '{10, 10, 10, 21};
		mbf_optype_t dk[4] = '{MBF_OP_BYTE, MBF_OP_BYTE, MBF_OP_NUM, MBF_OP_BYTE};
		int dv[4] = '{50, 50, 510, 20};
		int ga[4] = '{49, 49, 510, 19};
		int n[4] = '{0, 193, 4, 4};
		logic [2:0] fe[4] = '{3'b100, 3'b100, 3'b001, 3'b010};
		logic [31:0] q;
		int cyc;
		for (int i = 0; i < 4; i++) begin
			mset(ga[i], 8'h5A);
			setops(sk[i], op(dk[i], dv[i]), n[i]);
			repeat (3) @(negedge clk);
			check("flags", {f_inv, f_ovl, f_rng}, fe[i]);
			go(cyc);
			check("refused start", cyc, 0);
			bus(1'b0, REG_STATUS, 32'h0000_0000, q);
			check("rejected", q[ST_REJ_BIT], 1'b1);
			mchk(ga[i], 8'h5A, "kept");
		end
		$display("Test errors done");
	endtask : t_err
	task automatic t_level();
		int cyc;
		setops(1, op(MBF_OP_NUM, 400), 1);
		wr(REG_CTRL, 32'h0000_0001);
		watch(cyc);
		check("level start", cyc, 0);
		go(cyc);
		check("edge start", cyc > 0, 1'b1);
		$display("Test level done");
	endtask : t_level
	// Copy mode run: two source bytes moved ascending, timed like fill
	task automatic t_copy();
		int cyc;
		mset(200, 8'hA1);
		mset(201, 8'hB2);
		setops(201, op(MBF_OP_NUM, 220), 2);
		wr(REG_CTRL, 32'h0000_0002);
		wr(REG_CTRL, 32'h0000_0003);
		watch(cyc);
		check("copy time", cyc > tgt(2) - 10 && cyc < tgt(2) + 10, 1'b1);
		mchk(220, 8'hA1, "copied low");
		mchk(221, 8'hB2, "copied high");
		wr(REG_CTRL, 32'h0000_0000);
		$display("Test copy done");
	endtask : t_copy
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fill();
		t_err();
		t_level();
		t_copy();
		results();
	end
endmodule : mbf_engine_tb
